// ===== core/sfx_defs.vh
// sfx_defs.vh: opcodes, id values, field positions and timing counts for the
// auxiliary command decoder of a serial nor flash.
// assumes: included by the core files and the bench top, once per compile unit.
`ifndef SFX_DEFS_VH
`define SFX_DEFS_VH

// ****************************************************************
// opcodes
// ****************************************************************
`define SFX_OP_MAKER_PART    8'h90
`define SFX_OP_IDENT         8'h9F
`define SFX_OP_HIPERF        8'hA3
`define SFX_OP_RELEASE       8'hAB
`define SFX_OP_POWER_DOWN    8'hB9
`define SFX_OP_CR_EXIT       8'hFF
`define SFX_OP_UNIQUE_ID     8'h4B
`define SFX_OP_PAUSE         8'h75
`define SFX_OP_CONTINUE      8'h7A
`define SFX_OP_SEC_ERASE     8'h44
`define SFX_OP_SEC_PROG      8'h42
`define SFX_OP_WR_STATUS     8'h01
`define SFX_OP_SE            8'h20
`define SFX_OP_BE32          8'h52
`define SFX_OP_BE64          8'hD8
`define SFX_OP_CE1           8'hC7
`define SFX_OP_CE2           8'h60
`define SFX_OP_PP            8'h02
`define SFX_OP_QPP           8'h32
`define SFX_OP_WRITE_ENABLE_COMMAND          8'h06

// ****************************************************************
// continuous read mode pattern (upper nibble)
// ****************************************************************
`define SFX_CRM_PATTERN      4'hA

// ****************************************************************
// identification values (arbitrary, not of any real part)
// ****************************************************************
`define SFX_MAKER_ID         8'h5A
`define SFX_PART_ID          8'h14
`define SFX_MEM_TYPE         8'h40
`define SFX_MEM_CAP          8'h15
`define SFX_UNIQUE_ID        64'h0123456789ABCDEF

// ****************************************************************
// addresses and field positions
// ****************************************************************
`define SFX_ADDR_ZERO        24'h000000
`define SFX_ADDR_ONE         24'h000001
`define SFX_SEC_ADDR_HI      23:10
`define SFX_SEC_ADDR_HI_ZERO 14'h0000

// ****************************************************************
// bit counts
// ****************************************************************
`define SFX_CNT_OPCODE       7'h08
`define SFX_CNT_ADDR_END     7'h20
`define SFX_CNT_UID_START    7'h28
`define SFX_CNT_MAX          7'h7F

// ****************************************************************
// timing
// ****************************************************************
`define SFX_CLK_NS           10
`define SFX_RESUME_NS        200
`define SFX_RESUME_CYC       (`SFX_RESUME_NS / `SFX_CLK_NS)
`define SFX_PAUSE_NS         100
`define SFX_PAUSE_CYC        (`SFX_PAUSE_NS / `SFX_CLK_NS)
`define SFX_TIMER_W          5
`define SFX_TIMER_ZERO       5'h00
`define SFX_TIMER_ONE        5'h01

`endif

// ===== core/sfx_uid_rom.v
// sfx_uid_rom.v: small registered rom of identification bytes.
// assumes: same clock as the decoder; index stable one cycle ahead of use.
`timescale 1ns/1ns
`default_nettype none
`include "sfx_defs.vh"

module sfx_uid_rom (
   // clock and reset
   input  wire       clk_sys,
   input  wire       reset_n,
   // read port
   input  wire [3:0] index,
   output reg  [7:0] data
);

   // ****************************************************************
   // table: 0..7 unique id msb first, 8 maker, 9 part, 10 type, 11 cap
   // ****************************************************************
   reg [7:0] next_data;
   wire [63:0] uid = `SFX_UNIQUE_ID;

   always @* begin
      case (index)
         4'h0: next_data = uid[63:56];
         4'h1: next_data = uid[55:48];
         4'h2: next_data = uid[47:40];
         4'h3: next_data = uid[39:32];
         4'h4: next_data = uid[31:24];
         4'h5: next_data = uid[23:16];
         4'h6: next_data = uid[15:8];
         4'h7: next_data = uid[7:0];
         4'h8: next_data = `SFX_MAKER_ID;
         4'h9: next_data = `SFX_PART_ID;
         4'hA: next_data = `SFX_MEM_TYPE;
         4'hB: next_data = `SFX_MEM_CAP;
         default: next_data = 8'hFF;
      endcase
   end

   always @(posedge clk_sys) begin
      if (!reset_n) begin
         data <= 8'h00;
      end else begin
         data <= next_data;
      end
   end

endmodule
`default_nettype wire

// ===== core/sfx_aux_cmd.v
// sfx_aux_cmd.v: auxiliary command decoder of a serial nor flash.
// assumes: spi mode 0 from a host; sclk far slower than clk_sys; the
// array engine outside reports busy/done and obeys start/pause/continue.
//
// Functional notes
// RL1: maker/part read: opcode, zero address, then maker then part id, msb first.
// RL2: address of one returns part id before maker id.
// RL3: identification read returns maker byte, memory type, memory capacity.
// RL4: identification bytes follow opcode directly, one bit per falling edge.
// RL5: identification opcode not decoded during erase or program cycle.
// RL6: chip select rise stops output, returns to standby.
// RL7: host sends high-performance opcode plus three dummy bytes first.
// RL8: release or power-down opcode leaves high performance mode.
// RL9: mode bits at pattern let the next fast read skip the opcode.
// RL10: while mode bits hold pattern, ordinary opcodes are not decoded.
// RL11: continuous-read exit opcode clears mode state; other lines ignored.
// RL12: unique id read: opcode, four dummy bytes, then 64-bit id.
// RL13: pause accepted only while program/erase runs, paused 0, busy 1.
// RL14: accepted pause sets paused at once, clears busy within pause latency.
// RL15: while paused, reject status write, security, erase, program opcodes.
// RL16: continue accepted only with paused 1 and busy 0.
// RL17: continue clears paused at once, sets busy within 200 ns.
// RL18: four 256-byte security registers; erase address bits 23:10 zero.
// RL19: security erase needs write enable latch set beforehand.
// RL20: chip select must rise on byte boundary, else command discarded.
// RL21: security erase starts on chip select rise; latch cleared before done.
// RL22: once lock flag is set, security erase is ignored forever; code blocks it only while otp_lock_flag is high.
// RL23: device samples input on rising sclk, drives output on falling.
// RL24: rejected commands change nothing; chip select rise returns to idle.
`timescale 1ns/1ns
`default_nettype none
`include "sfx_defs.vh"

module sfx_aux_cmd (
   // clock and reset
   input  wire       clk_sys,
   input  wire       reset_n,
   // spi pins
   input  wire       cs_n,
   input  wire       sclk,
   input  wire       si,
   output reg        so,
   output reg        so_oe,
   // continuous read mode bits from the fast read path
   input  wire       crm_valid,
   input  wire [7:0] continuous_read_mode_bits,
   output reg        continuous_read_mode,
   // array engine status and control
   input  wire       array_busy,
   input  wire       array_pgm_erase,
   input  wire       array_done,
   input  wire       otp_lock_flag,
   input  wire       write_enable_command,
   output reg        write_enable_latch,
   output reg        write_in_progress,
   output reg        paused_flag,
   output reg        pause_request,
   output reg        continue_request,
   output reg        sec_erase_start,
   output reg        high_performance_mode,
   output reg        cmd_rejected
);

   // ****************************************************************
   // pin synchronisers and edge detection
   // ****************************************************************
   reg [1:0] cs_sync;
   reg [1:0] ck_sync;
   reg [1:0] si_sync;
   reg       ck_last;
   reg       cs_last;

   always @(posedge clk_sys) begin
      if (!reset_n) begin
         cs_sync <= 2'h3;
         ck_sync <= 2'h0;
         si_sync <= 2'h0;
         ck_last <= 1'b0;
         cs_last <= 1'b1;
      end else begin
         cs_sync <= {cs_sync[0], cs_n};
         ck_sync <= {ck_sync[0], sclk};
         si_sync <= {si_sync[0], si};
         ck_last <= ck_sync[1];
         cs_last <= cs_sync[1];
      end
   end

   wire sel     = ~cs_sync[1];
   wire ck_rise = sel & ck_sync[1] & ~ck_last;
   wire ck_fall = sel & ~ck_sync[1] & ck_last;
   wire cs_rise = cs_sync[1] & ~cs_last;
   wire cs_fall = ~cs_sync[1] & cs_last;

   // ****************************************************************
   // command states, one-hot
   // ****************************************************************
   localparam [6:0] ST_OPC   = 7'h01;
   localparam [6:0] ST_MAKER = 7'h02;
   localparam [6:0] ST_IDENT = 7'h04;
   localparam [6:0] ST_UID   = 7'h08;
   localparam [6:0] ST_HPM   = 7'h10;
   localparam [6:0] ST_SECER = 7'h20;
   localparam [6:0] ST_IGN   = 7'h40;

   reg [6:0]  state;
   reg [6:0]  bit_cnt;
   reg [7:0]  opcode;
   reg [23:0] addr;
   reg        part_first;
   reg [7:0]  out_shift;
   reg [3:0]  rom_idx;
   wire [7:0] rom_data;
   reg        sec_erasing;

   wire [7:0] opc_next = {opcode[6:0], si_sync[1]};
   wire       erase_or_prog_busy = write_in_progress;

   // commands blocked while a program or erase is paused
   function paused_block;
      input [7:0] op;
      begin
         paused_block = (op == `SFX_OP_WR_STATUS) | (op == `SFX_OP_SEC_ERASE) |
                        (op == `SFX_OP_SEC_PROG)  | (op == `SFX_OP_SE)       |
                        (op == `SFX_OP_BE32)      | (op == `SFX_OP_BE64)     |
                        (op == `SFX_OP_CE1)       | (op == `SFX_OP_CE2)      |
                        (op == `SFX_OP_PP)        | (op == `SFX_OP_QPP);
      end
   endfunction

   sfx_uid_rom u_rom (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .index   (rom_idx),
      .data    (rom_data)
   );

   // ****************************************************************
   // serial decode
   // ****************************************************************
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         state         <= ST_OPC;
         bit_cnt       <= 7'h00;
         opcode        <= 8'h00;
         addr          <= 24'h000000;
         part_first    <= 1'b0;
         cmd_rejected  <= 1'b0;
      end else if (cs_fall) begin
         state         <= ST_OPC;
         bit_cnt       <= 7'h00;
         cmd_rejected  <= 1'b0;
      end else if (ck_rise) begin // [RL23]
         if (bit_cnt != `SFX_CNT_MAX) begin
            bit_cnt <= bit_cnt + 7'h01;
         end
         if (bit_cnt < `SFX_CNT_OPCODE) begin
            opcode <= opc_next;
         end else if (bit_cnt < `SFX_CNT_ADDR_END) begin
            addr <= {addr[22:0], si_sync[1]};
         end
         case (state)
            ST_OPC: begin
               if (bit_cnt == (`SFX_CNT_OPCODE - 7'h01)) begin
                  if (continuous_read_mode) begin
                     // only the exit opcode on io0 is looked at [RL10] [RL11]
                     state <= ST_IGN;
                  end else if (paused_flag & paused_block(opc_next)) begin
                     state        <= ST_IGN; // [RL15]
                     cmd_rejected <= 1'b1;   // [RL24]
                  end else begin
                     case (opc_next)
                        `SFX_OP_MAKER_PART: state <= ST_MAKER;
                        `SFX_OP_IDENT: begin
                           if (erase_or_prog_busy) begin
                              state <= ST_IGN; // [RL5]
                           end else begin
                              state <= ST_IDENT;
                           end
                        end
                        `SFX_OP_UNIQUE_ID:  state <= ST_UID;
                        `SFX_OP_HIPERF:     state <= ST_HPM;
                        `SFX_OP_SEC_ERASE:  state <= ST_SECER;
                        default: state <= ST_IGN;
                     endcase
                  end
               end
            end
            ST_MAKER: begin
               if (bit_cnt == (`SFX_CNT_ADDR_END - 7'h01)) begin
                  part_first <= ({addr[22:0], si_sync[1]} ==
                                 `SFX_ADDR_ONE); // [RL2]
               end
            end
            default: begin
               state <= state;
            end
         endcase
      end
   end

   // ****************************************************************
   // output shifting on falling sclk edges
   // ****************************************************************
   // rom index changes on the rise before the byte's first fall so the registered data is ready
   wire out_phase = (state == ST_MAKER) ? (bit_cnt >= `SFX_CNT_ADDR_END) :
                    (state == ST_IDENT) ? (bit_cnt >= `SFX_CNT_OPCODE) :
                    (state == ST_UID)   ? (bit_cnt >= `SFX_CNT_UID_START) :
                    1'b0;
   wire [6:0] out_bits = bit_cnt - ((state == ST_MAKER) ? `SFX_CNT_ADDR_END :
                         (state == ST_UID) ? `SFX_CNT_UID_START :
                         `SFX_CNT_OPCODE);
   wire [3:0] byte_no = {1'b0, out_bits[5:3]};

   always @* begin
      case (state)
         ST_MAKER: rom_idx = (part_first ^ byte_no[0]) ? 4'h9 : 4'h8; // [RL1]
         ST_IDENT: rom_idx = (byte_no == 4'h0) ? 4'h8 :
                             (byte_no == 4'h1) ? 4'hA : 4'hB;          // [RL3]
         ST_UID:   rom_idx = {1'b0, byte_no[2:0]};                     // [RL12]
         default:  rom_idx = 4'h8;
      endcase
   end

   always @(posedge clk_sys) begin
      if (!reset_n) begin
         so        <= 1'b0;
         so_oe     <= 1'b0;
         out_shift <= 8'h00;
      end else if (!sel) begin
         so_oe <= 1'b0; // [RL6]
      end else if (ck_fall & out_phase) begin // [RL4] [RL23]
         so_oe <= 1'b1;
         if (out_bits[2:0] == 3'h0) begin
            so        <= rom_data[7];
            out_shift <= {rom_data[6:0], 1'b0};
         end else begin
            so        <= out_shift[7];
            out_shift <= {out_shift[6:0], 1'b0};
         end
      end
   end

   // ****************************************************************
   // mode flags, suspend, resume, security erase
   // ****************************************************************
   reg [`SFX_TIMER_W-1:0] timer;
   reg                    resuming;
   reg                    pausing;
   wire ends_on_byte = (bit_cnt[2:0] == 3'h0);
   wire sec_ok = (bit_cnt == `SFX_CNT_ADDR_END) &
                 (addr[`SFX_SEC_ADDR_HI] == `SFX_SEC_ADDR_HI_ZERO); // [RL18]

   always @(posedge clk_sys) begin
      if (!reset_n) begin
         continuous_read_mode  <= 1'b0;
         high_performance_mode <= 1'b0;
         write_enable_latch    <= 1'b0;
         write_in_progress     <= 1'b0;
         paused_flag           <= 1'b0;
         pause_request         <= 1'b0;
         continue_request      <= 1'b0;
         sec_erase_start       <= 1'b0;
         sec_erasing           <= 1'b0;
         timer                 <= `SFX_TIMER_ZERO;
         resuming              <= 1'b0;
         pausing               <= 1'b0;
      end else begin
         pause_request    <= 1'b0;
         continue_request <= 1'b0;
         sec_erase_start  <= 1'b0;
         if (crm_valid) begin
            continuous_read_mode <= (continuous_read_mode_bits[7:4] ==
                                     `SFX_CRM_PATTERN); // [RL9]
         end else if (ck_rise & (state == ST_OPC) & continuous_read_mode &
                      (bit_cnt == (`SFX_CNT_OPCODE - 7'h01)) &
                      (opc_next == `SFX_OP_CR_EXIT)) begin
            continuous_read_mode <= 1'b0; // [RL11]
         end
         if (write_enable_command & ~write_in_progress) begin
            write_enable_latch <= 1'b1;
         end
         // busy is set from the engine unless paused or a pause or continue is in flight
         if (array_busy & ~pausing & ~resuming & ~paused_flag) begin
            write_in_progress <= 1'b1;
         end
         if (array_done | (sec_erasing & array_done)) begin
            write_in_progress <= 1'b0;
            sec_erasing       <= 1'b0;
         end
         if (pausing | resuming) begin
            timer <= timer + `SFX_TIMER_ONE;
         end
         if (pausing & (timer == (`SFX_PAUSE_CYC - `SFX_TIMER_ONE))) begin
            write_in_progress <= 1'b0; // [RL14]
            pausing           <= 1'b0;
         end
         if (resuming & (timer == (`SFX_RESUME_CYC - `SFX_TIMER_ONE))) begin
            write_in_progress <= 1'b1; // [RL17]
            resuming          <= 1'b0;
         end
         if (cs_rise & (state == ST_IGN) & ~continuous_read_mode &
             (bit_cnt == `SFX_CNT_OPCODE)) begin // [RL20]
            if ((opcode == `SFX_OP_RELEASE) |
                (opcode == `SFX_OP_POWER_DOWN)) begin
               high_performance_mode <= 1'b0; // [RL8]
            end
            if ((opcode == `SFX_OP_PAUSE) & ~paused_flag & write_in_progress &
                array_pgm_erase & ~pausing & ~resuming) begin // [RL13]
               paused_flag   <= 1'b1; // [RL14]
               pause_request <= 1'b1;
               pausing       <= 1'b1;
               timer         <= `SFX_TIMER_ZERO;
            end
            if ((opcode == `SFX_OP_CONTINUE) & paused_flag &
                ~write_in_progress) begin // [RL16]
               paused_flag      <= 1'b0; // [RL17]
               continue_request <= 1'b1;
               resuming         <= 1'b1;
               timer            <= `SFX_TIMER_ZERO;
            end
         end
         if (cs_rise & (state == ST_HPM) & ends_on_byte &
             (bit_cnt == `SFX_CNT_ADDR_END)) begin
            high_performance_mode <= 1'b1;
         end
         // security erase: latch, lock and busy checked on chip select rise
         if (cs_rise & (state == ST_SECER) & sec_ok & write_enable_latch &
             ~otp_lock_flag & ~write_in_progress & ~paused_flag) begin
            // [RL19] [RL20] [RL22] [RL21]
            sec_erase_start    <= 1'b1;
            sec_erasing        <= 1'b1;
            write_in_progress  <= 1'b1;
            write_enable_latch <= 1'b0; // cleared well before completion
         end
      end
   end

endmodule
`default_nettype wire

// ===== tb/sfx_aux_cmd_sva.sv
// sfx_aux_cmd_sva.sv: port checks of the aux command decoder.
// assumes: bound to sfx_aux_cmd; one clock, sync reset.
`timescale 1ns/1ns
`default_nettype none
module sfx_aux_cmd_sva (
   // clock and reset
   input wire logic       clk_sys,
   input wire logic       reset_n,
   // pins and mode bits
   input wire logic       cs_n,
   input wire logic       so_oe,
   input wire logic       crm_valid,
   input wire logic [7:0] continuous_read_mode_bits,
   input wire logic       continuous_read_mode,
   // engine side
   input wire logic       array_pgm_erase,
   input wire logic       otp_lock_flag,
   input wire logic       write_enable_latch,
   input wire logic       write_in_progress,
   input wire logic       paused_flag,
   input wire logic       pause_request,
   input wire logic       continue_request,
   input wire logic       sec_erase_start
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // *****
   // pause, continue, security erase, output enable and mode checks
   // *****
   sequence s_pause_done;
      paused_flag ##[1:11] !write_in_progress;
   endsequence
   sequence s_resume_done;
      !paused_flag ##[1:21] write_in_progress;
   endsequence
   AST_PAUSE_GATE: assert property (pause_request |-> array_pgm_erase
      && $past(write_in_progress) && !$past(paused_flag)) else $error("pause");
   AST_PAUSE_RUN: assert property (pause_request |-> s_pause_done)
      else $error("pause run");
   AST_CONT_GATE: assert property (continue_request |->
      $past(paused_flag) && !$past(write_in_progress)) else $error("cont");
   AST_CONT_RUN: assert property (continue_request |-> s_resume_done)
      else $error("cont run");
   AST_SEC_GATE: assert property (sec_erase_start |-> cs_n
      && $past(write_enable_latch) && !otp_lock_flag) else $error("sec");
   AST_SEC_RUN: assert property (sec_erase_start |->
      ##[0:2] (write_in_progress && !write_enable_latch)) else $error("run");
   AST_OE_CS: assert property (cs_n [*4] |-> !so_oe) else $error("oe");
   AST_OE_WIP: assert property ($rose(so_oe) |-> !write_in_progress)
      else $error("oe busy");
   AST_CRM_SET: assert property ($rose(continuous_read_mode) |->
      $past(crm_valid) && $past(continuous_read_mode_bits[7:4]) == 4'hA)
      else $error("crm");
   AST_CRM_EXIT: assert property ($fell(continuous_read_mode) |->
      !cs_n || $past(crm_valid)) else $error("crm exit");
endmodule
bind sfx_aux_cmd sfx_aux_cmd_sva sfx_aux_cmd_sva_i (.clk_sys, .reset_n, .cs_n,
   .so_oe, .crm_valid, .continuous_read_mode_bits, .continuous_read_mode,
   .array_pgm_erase, .otp_lock_flag, .write_enable_latch, .write_in_progress,
   .paused_flag, .pause_request, .continue_request, .sec_erase_start);
`default_nettype wire

// ===== tb/sfx_host_model.sv
// sfx_host_model.sv: spi mode 0 host for the decoder pins.
// assumes: bench calls xfer; sclk stands low outside frames.
`timescale 1ns/1ns
`default_nettype none
module sfx_host_model (
   // clock
   input  wire logic clk_sys,
   // spi pins
   output var  logic cs_n,
   output var  logic sclk,
   output var  logic si,
   input  wire logic so,
   input  wire logic so_oe
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si = 1'b0;
   end
   // idle data line toggles so a stale bit is never mistaken for data
   always @(posedge clk_sys) if (cs_n) si <= ~si;
   // so taken before the next fall; a released line reads inverted
   task automatic xfer(input logic [127:0] tx, input int n,
                       output logic [127:0] rx, output logic oe);
      int i;
      rx = '0;
      oe = 1'b0;
      @(posedge clk_sys) cs_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      for (i = 0; i < n; i++) begin
         @(posedge clk_sys);
         rx = {rx[126:0], so_oe ? so : ~so};
         oe = oe | so_oe;
         si <= tx[127 - i];
         sclk <= 1'b0;
         repeat (4) @(posedge clk_sys);
         sclk <= 1'b1;
         repeat (3) @(posedge clk_sys);
      end
      @(posedge clk_sys);
      rx = {rx[126:0], so_oe ? so : ~so};
      sclk <= 1'b0;
      repeat (4) @(posedge clk_sys);
      cs_n <= 1'b1;
      repeat (6) @(posedge clk_sys);
   endtask
endmodule
`default_nettype wire

// ===== tb/sfx_aux_cmd_tb_top.sv
// sfx_aux_cmd_tb_top.sv: self-checking bench of the aux command decoder.
// assumes: host model drives the pins; engine inputs are driven here.
`timescale 1ns/1ns
`default_nettype none
`include "sfx_defs.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
   $display("unexpected at %0t got %h expected %h", $time, g, e); end end
module sfx_aux_cmd_tb_top;
   logic         clk_sys = 1'b0, reset_n = 1'b0, otp_lock_flag = 1'b0;
   logic         array_busy = 1'b0, array_pgm_erase = 1'b0, oe;
   logic [2:0]   pl = 3'b000;
   logic [7:0]   continuous_read_mode_bits = 8'h00, exp_q[$];
   logic [7:0]   blk[10] = '{8'h01, 8'h44, 8'h42, 8'h20, 8'h52, 8'hD8,
                             8'hC7, 8'h60, 8'h02, 8'h32};
   logic [31:0]  seed = 32'h000132EF;
   logic [127:0] rx;
   wire          write_enable_command = pl[0], array_done = pl[1];
   wire          crm_valid = pl[2], cs_n, sclk, si, so, so_oe;
   wire          continuous_read_mode, write_enable_latch, paused_flag;
   wire          write_in_progress, pause_request, continue_request;
   wire          sec_erase_start, high_performance_mode, cmd_rejected;
   int           errors = 0, samples_checked = 0, cycles = 0, k;
   int           n_pause = 0, n_cont = 0, n_sec = 0;
   sfx_aux_cmd sfx_aux_cmd_i (.clk_sys, .reset_n, .cs_n, .sclk, .si, .so,
      .so_oe, .crm_valid, .continuous_read_mode_bits, .continuous_read_mode,
      .array_busy, .array_pgm_erase, .array_done, .otp_lock_flag,
      .write_enable_command, .write_enable_latch, .write_in_progress,
      .paused_flag, .pause_request, .continue_request, .sec_erase_start,
      .high_performance_mode, .cmd_rejected);
   sfx_host_model sfx_host_model_i (.clk_sys, .cs_n, .sclk, .si, .so, .so_oe);
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles++;
      n_pause += pause_request;
      n_cont += continue_request;
      n_sec += sec_erase_start;
      if (cycles == 30000) begin
         errors++;
         complete_run();
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic complete_run;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic pulse(input int w);
      @(posedge clk_sys) pl[w] <= 1'b1;
      @(posedge clk_sys) pl <= 3'b000;
      repeat (4) @(posedge clk_sys);
   endtask
   task automatic run(input logic [127:0] tx, input int n);
      sfx_host_model_i.xfer(tx, n, rx, oe);
   endtask
   task automatic chk_out(input string s);
      int m;
      m = exp_q.size();
      for (k = 0; k < m; k++) `CHK(rx[8*(m-k)-1 -: 8], exp_q[k])
      exp_q.delete();
      $display("test %s done", s);
   endtask
   initial begin
      repeat (3) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (6) @(posedge clk_sys);
      // *****
      // identification reads
      // *****
      exp_q = {`SFX_MAKER_ID, `SFX_PART_ID, `SFX_MAKER_ID, `SFX_PART_ID};
      run({`SFX_OP_MAKER_PART, 24'h000000, 96'h0}, 64);
      chk_out("maker");
      exp_q = {`SFX_PART_ID, `SFX_MAKER_ID};
      run({`SFX_OP_MAKER_PART, 24'h000001, 96'h0}, 48);
      chk_out("part");
      exp_q = {`SFX_MAKER_ID, `SFX_MEM_TYPE, `SFX_MEM_CAP};
      run({`SFX_OP_IDENT, 120'h0}, 32);
      chk_out("ident");
      run({`SFX_OP_IDENT, 120'h0}, 20);
      `CHK(rx[11:4], `SFX_MAKER_ID)
      `CHK(so_oe, 1'b0)
      run({`SFX_OP_UNIQUE_ID, 120'h0}, 104);
      `CHK(rx[63:0], `SFX_UNIQUE_ID)
      // *****
      // modes
      // *****
      for (k = 0; k < 2; k++) begin
         run({`SFX_OP_HIPERF, 120'h0}, 32);
         `CHK(high_performance_mode, 1'b1)
         run({k ? `SFX_OP_RELEASE : `SFX_OP_POWER_DOWN, 120'h0}, 8);
         `CHK(high_performance_mode, 1'b0)
         seed = lfsr(seed);
         @(posedge clk_sys) continuous_read_mode_bits <=
            {k ? `SFX_CRM_PATTERN : 4'h5, seed[3:0]};
         pulse(2);
         `CHK(continuous_read_mode, k[0])
      end
      run({`SFX_OP_IDENT, 120'h0}, 32);
      `CHK(oe, 1'b0)
      run({`SFX_OP_CR_EXIT, 120'h0}, 8);
      `CHK(continuous_read_mode, 1'b0)
      $display("test modes done");
      // *****
      // security erase
      // *****
      run({`SFX_OP_SEC_ERASE, 120'h0}, 32);
      pulse(0);
      `CHK(write_enable_latch, 1'b1)
      @(posedge clk_sys) otp_lock_flag <= 1'b1;
      run({`SFX_OP_SEC_ERASE, 120'h0}, 32);
      @(posedge clk_sys) otp_lock_flag <= 1'b0;
      run({`SFX_OP_SEC_ERASE, 120'h0}, 31);
      run({`SFX_OP_SEC_ERASE, 24'h000400, 96'h0}, 32);
      `CHK(n_sec, 0)
      `CHK(write_enable_latch, 1'b1)
      seed = lfsr(seed);
      run({`SFX_OP_SEC_ERASE, 14'h0000, seed[9:0], 96'h0}, 32);
      `CHK(n_sec, 1)
      `CHK({write_in_progress, write_enable_latch}, 2'b10)
      run({`SFX_OP_IDENT, 120'h0}, 32);
      `CHK(oe, 1'b0)
      pulse(1);
      `CHK(write_in_progress, 1'b0)
      $display("test erase done");
      // *****
      // pause and continue
      // *****
      run({`SFX_OP_PAUSE, 120'h0}, 8);
      `CHK(n_pause, 0)
      @(posedge clk_sys) {array_busy, array_pgm_erase} <= 2'b11;
      repeat (4) @(posedge clk_sys);
      run({`SFX_OP_PAUSE, 120'h0}, 8);
      `CHK(n_pause, 1)
      `CHK(paused_flag, 1'b1)
      repeat (10) @(posedge clk_sys);
      `CHK(write_in_progress, 1'b0)
      for (k = 0; k < 10; k++) begin
         run({blk[k], 120'h0}, 8);
         `CHK(cmd_rejected, 1'b1)
      end
      `CHK(n_sec, 1)
      run({`SFX_OP_CONTINUE, 120'h0}, 8);
      `CHK(n_cont, 1)
      `CHK(paused_flag, 1'b0)
      repeat (20) @(posedge clk_sys);
      `CHK(write_in_progress, 1'b1)
      run({`SFX_OP_CONTINUE, 120'h0}, 8);
      `CHK(n_cont, 1)
      @(posedge clk_sys) {array_busy, array_pgm_erase} <= 2'b00;
      pulse(1);
      $display("test pause done");
      complete_run();
   end
endmodule
`default_nettype wire
